/* File: hw/upstream_burst_block_framer.sv */
/*
 * Upstream burst block framer: turns received bursts into typed,
 * length-prefixed blocks (all but the channel tag) for the MAC, one byte per clock.
 * Assumes burst source, descriptor and code-block pulses on i_clk,
 * and a MAC that takes every byte while o_valid is high.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ubf_defs.svh"

module upstream_burst_block_framer import ubf_pkg::*; #(
	parameter int CHUNK = `UBF_CHUNK,
	parameter int VS_MAX = `UBF_VS_MAX
) (
	input wire logic i_clk, // 20 MHz
	input wire logic i_rst_b, // async, active low
	input wire logic i_burst_start, // burst opens, pulse
	input wire logic i_no_burst, // opportunity empty, pulse
	input wire logic [3:0] i_interval_usage_code, // from descriptor
	input wire logic [13:0] i_service_flow_id, // from descriptor
	input wire logic [31:0] i_burst_start_slot_index, // start slot
	input wire logic i_new_descriptor, // first frame on new descriptor
	input wire logic i_fec_enable, // coding on for interval
	input wire logic [2:0] i_channel, // logical channel
	input wire logic i_collision, // no-burst cause
	input wire logic i_no_energy, // no-burst cause
	input wire logic [15:0] i_opportunity_length, // interval length
	input wire logic [7:0] i_in_data, // burst byte
	input wire logic i_in_valid, // burst byte valid
	input wire logic i_in_last, // last burst byte
	input wire logic i_rx_internal_error, // sampled with last byte
	input wire logic i_low_energy, // sampled with last byte
	input wire logic i_high_energy, // sampled with last byte
	input wire logic i_clean_code_block, // pulse
	input wire logic i_fixed_code_block, // pulse
	input wire logic i_failed_code_block, // pulse
	input wire logic [7:0] i_addr, // register byte address
	input wire logic [31:0] i_wr_data, // register write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [31:0] o_rd_data, // read data, cycle after strobe
	output logic [7:0] o_data, // block byte to MAC
	output logic o_valid, // block byte valid
	output logic o_in_ready, // burst byte taken when high
	output logic o_busy, // series in progress
	output logic o_irq // level interrupt
);
	localparam int CA = $clog2(CHUNK);
	localparam int VA = $clog2(VS_MAX);

	typedef struct packed {
		fr_state_t st;
		logic [7:0] idx;
		logic [7:0] k;
		logic [15:0] len;
		logic [7:0] kind;
		logic first;
		logic last_seen;
		logic nb;
		logic [3:0] usage;
		logic [13:0] flow;
		logic [31:0] slot;
		logic new_desc;
		logic fec_en;
		logic [2:0] chan;
		logic coll;
		logic noen;
		logic [15:0] opp_len;
		logic err;
		logic lowe;
		logic highe;
		logic [7:0] clean;
		logic [7:0] fixd;
		logic [7:0] fail;
		logic counting;
		logic vs_go;
		logic [7:0] vs_len;
		logic [VS_MAX-1:0][7:0] vs_mem;
		logic [CHUNK-1:0][7:0] chunk;
		logic tag_en;
		logic [3:0] int_stat;
		logic [3:0] int_mask;
		logic [31:0] rd_data;
		logic [7:0] data;
		logic valid;
		logic in_ready;
		logic busy;
		logic irq;
	} fr_regs_t;

	fr_regs_t r;
	fr_regs_t next_r;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	function automatic logic [7:0] pre_len(input logic [7:0] kind);
		return (kind == `UBF_T_HEADER) ? `UBF_HDR_FIX :
			(kind == `UBF_T_NOBURST) ? `UBF_NB_FIX : 8'h00;
	endfunction

	function automatic logic [7:0] slot_byte(input logic [31:0] s,
			input logic [1:0] j);
		return s[8*(3-j) +: 8];
	endfunction

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		logic [7:0] pn;
		logic [7:0] dn;
		logic [7:0] off;
		logic [7:0] b;
		logic [3:0] ev;
		logic [7:0] nk;
		logic fin;
		pn = pre_len(r.kind);
		dn = (r.kind == `UBF_T_VENDOR) ? r.vs_len : r.k;
		off = 8'h00;
		b = 8'h00;
		ev = 4'h0;
		nk = r.k + 8'h01;
		fin = 1'b0;
		next_r = r;
		next_r.valid = 1'b0;
		next_r.data = 8'h00;
		next_r.rd_data = 32'h0;

		if (r.counting) begin
			if (i_clean_code_block)
				next_r.clean = sat_inc(r.clean);
			if (i_fixed_code_block)
				next_r.fixd = sat_inc(r.fixd);
			if (i_failed_code_block)
				next_r.fail = sat_inc(r.fail);
		end

		// payload byte at idx: fixed prefix, data, fixed suffix
		if (r.idx < pn) begin
			if (r.kind == `UBF_T_HEADER) begin
				unique case (r.idx)
					8'h00: b = {2'b00, r.new_desc, r.vs_go, r.usage};
					8'h01: b = {2'b00, r.flow[13:8]};
					8'h02: b = r.flow[7:0];
					default: b = slot_byte(r.slot, 2'(r.idx - 8'h03));
				endcase
			end else begin
				unique case (r.idx)
					8'h00: b = {r.coll, r.noen, r.flow[13:8]};
					8'h01: b = r.flow[7:0];
					8'h06: b = {4'h0, r.usage};
					8'h07: b = r.opp_len[15:8];
					8'h08: b = r.opp_len[7:0];
					default: b = slot_byte(r.slot, 2'(r.idx - 8'h02));
				endcase
			end
		end else if (r.idx < pn + dn) begin
			off = r.idx - pn;
			if (r.kind == `UBF_T_VENDOR)
				b = r.vs_mem[off[VA-1:0]];
			else
				b = r.chunk[off[CA-1:0]];
		end else begin
			off = r.idx - pn - dn;
			unique case (off[1:0])
				2'b00: b = {5'b00000, r.err, r.lowe, r.highe};
				2'b01: b = r.fec_en ? r.clean : 8'h00;
				2'b10: b = r.fec_en ? r.fixd : 8'h00;
				default: b = r.fec_en ? r.fail : 8'h00;
			endcase
		end

		unique case (r.st)
			ST_IDLE: begin
				if (i_burst_start) begin
					next_r.first = 1'b1;
					next_r.last_seen = 1'b0;
					next_r.nb = 1'b0;
					next_r.k = 8'h00;
					next_r.counting = 1'b1;
					next_r.clean = 8'h00;
					next_r.fixd = 8'h00;
					next_r.fail = 8'h00;
					next_r.vs_go = (r.vs_len != 8'h00);
					next_r.st = r.tag_en ? ST_TAG : ST_COLLECT;
				end else if (i_no_burst) begin
					next_r.nb = 1'b1;
					next_r.kind = `UBF_T_NOBURST;
					next_r.len = {8'h00, `UBF_NB_FIX};
					next_r.st = r.tag_en ? ST_TAG : ST_TYPE;
				end
				if (i_burst_start || i_no_burst) begin
					next_r.usage = i_interval_usage_code;
					next_r.flow = i_service_flow_id;
					next_r.slot = i_burst_start_slot_index;
					next_r.new_desc = i_new_descriptor;
					next_r.fec_en = i_fec_enable;
					next_r.chan = i_channel;
					next_r.coll = i_collision;
					next_r.noen = i_no_energy;
					next_r.opp_len = i_opportunity_length;
					next_r.idx = 8'h00;
				end
			end
			ST_TAG: begin
				next_r.valid = 1'b1;
				next_r.data = (r.idx == 8'h00) ? `UBF_T_TAG :
					{5'b00000, r.chan};
				next_r.idx = r.idx + 8'h01;
				if (r.idx == 8'h01) begin
					next_r.idx = 8'h00;
					next_r.st = r.nb ? ST_TYPE : ST_COLLECT;
				end
			end
			ST_COLLECT: begin
				if (i_in_valid && r.in_ready) begin
					next_r.chunk[r.k[CA-1:0]] = i_in_data;
					next_r.k = nk;
					if (i_in_last) begin
						next_r.last_seen = 1'b1;
						next_r.err = i_rx_internal_error;
						next_r.lowe = i_low_energy;
						next_r.highe = i_high_energy;
					end
					// full chunks keep the data of every middle block, and of a header with more data to follow, at 16 bytes
					if (i_in_last || nk == 8'(CHUNK)) begin
						next_r.st = ST_TYPE;
						if (r.first) begin
							next_r.kind = `UBF_T_HEADER;
							next_r.len = 16'(nk) + 16'(`UBF_HDR_FIX);
						end else if (i_in_last) begin
							next_r.kind = `UBF_T_TRAILER;
							next_r.len = 16'(nk) + 16'(`UBF_TRL_FIX);
							next_r.counting = 1'b0;
						end else begin
							next_r.kind = `UBF_T_MIDDLE;
							next_r.len = 16'(nk);
						end
					end
				end
			end
			ST_TYPE: begin
				next_r.valid = 1'b1;
				next_r.data = r.kind;
				next_r.st = ST_LEN_HI;
			end
			ST_LEN_HI: begin
				next_r.valid = 1'b1;
				next_r.data = r.len[15:8];
				next_r.st = ST_LEN_LO;
			end
			ST_LEN_LO: begin
				next_r.valid = 1'b1;
				next_r.data = r.len[7:0];
				next_r.idx = 8'h00;
				if (r.len == 16'h0000)
					fin = 1'b1;
				else
					next_r.st = ST_PAY;
			end
			ST_PAY: begin
				next_r.valid = 1'b1;
				next_r.data = b;
				next_r.idx = r.idx + 8'h01;
				fin = ({8'h00, r.idx} == r.len - 16'h0001);
			end
			default: next_r.st = ST_IDLE;
		endcase

		// block finished: pick the next block of the series
		if (fin) begin
			next_r.idx = 8'h00;
			next_r.first = 1'b0;
			if ((r.kind == `UBF_T_HEADER && !r.last_seen) ||
					r.kind == `UBF_T_MIDDLE) begin
				next_r.k = 8'h00;
				next_r.st = ST_COLLECT;
			end else if (r.kind == `UBF_T_HEADER) begin
				next_r.k = 8'h00;
				next_r.kind = `UBF_T_TRAILER;
				next_r.len = {8'h00, `UBF_TRL_FIX};
				next_r.counting = 1'b0;
				next_r.st = ST_TYPE;
			end else if (r.kind == `UBF_T_TRAILER && r.vs_go) begin
				next_r.kind = `UBF_T_VENDOR;
				next_r.len = {8'h00, r.vs_len};
				next_r.st = ST_TYPE;
			end else begin
				if (r.kind == `UBF_T_VENDOR)
					next_r.vs_len = 8'h00;
				ev[`UBF_I_BURST] = !r.nb;
				ev[`UBF_I_NOBURST] = r.nb;
				next_r.st = ST_IDLE;
			end
		end

		// -------------------------------------------------------------
		// register port
		// -------------------------------------------------------------
		if (r.st != ST_IDLE && (i_burst_start || i_no_burst))
			ev[`UBF_I_DROP] = 1'b1;
		if (i_wr) begin
			unique case (i_addr)
				`UBF_A_CTRL: next_r.tag_en = i_wr_data[0];
				`UBF_A_INT_MASK: next_r.int_mask = i_wr_data[3:0];
				`UBF_A_VS_LEN: if (r.st == ST_IDLE) next_r.vs_len = 8'h00;
				`UBF_A_VS_DATA: begin
					// loaded between bursts only; a full buffer drops the byte
					if (r.st == ST_IDLE && r.vs_len < 8'(VS_MAX)) begin
						next_r.vs_mem[r.vs_len[VA-1:0]] = i_wr_data[7:0];
						next_r.vs_len = r.vs_len + 8'h01;
					end else if (r.st == ST_IDLE)
						ev[`UBF_I_VS_OVF] = 1'b1;
				end
				default: ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				`UBF_A_CTRL: next_r.rd_data = {31'h0, r.tag_en};
				`UBF_A_INT_STAT: next_r.rd_data = {28'h0, r.int_stat};
				`UBF_A_INT_MASK: next_r.rd_data = {28'h0, r.int_mask};
				`UBF_A_VS_LEN: next_r.rd_data = {24'h0, r.vs_len};
				`UBF_A_STATUS: next_r.rd_data = {24'h0, r.st != ST_IDLE,
					r.last_seen, r.first, r.nb, 1'b0, r.chan};
				default: next_r.rd_data = 32'h0;
			endcase
		end
		// a new event wins over the read that clears the status
		if (i_rd && i_addr == `UBF_A_INT_STAT)
			next_r.int_stat = ev;
		else
			next_r.int_stat = r.int_stat | ev;
		next_r.irq = |(next_r.int_stat & next_r.int_mask);
		next_r.in_ready = (next_r.st == ST_COLLECT);
		next_r.busy = (next_r.st != ST_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.tag_en <= `UBF_RST_CTRL;
			r.int_mask <= `UBF_RST_MASK;
		end else begin
			r <= next_r;
		end
	end

	assign o_rd_data = r.rd_data;
	assign o_data = r.data;
	assign o_valid = r.valid;
	assign o_in_ready = r.in_ready;
	assign o_busy = r.busy;
	assign o_irq = r.irq;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_prefix;
		o_valid ##1 o_valid ##1 o_valid;
	endsequence
	sequence s_tag_out;
		o_data == `UBF_T_TAG ##1 o_data[7:3] == 5'b00000;
	endsequence

	chk_prefix_bytes: assert property ((r.st == ST_TYPE) |=>
		s_prefix and (r.st == ST_LEN_HI ##1 r.st == ST_LEN_LO))
		else $error("block prefix not three bytes");
	chk_tag_shape: assert property ((r.st == ST_TAG && r.idx == 8'h00)
		|=> s_tag_out) else $error("bad channel tag block");
	chk_type_legal: assert property ((r.st == ST_TYPE) |=>
		o_data >= `UBF_T_HEADER && o_data <= `UBF_T_NOBURST)
		else $error("reserved block type");
	chk_vendor_len: assert property ((r.st == ST_TYPE &&
		r.kind == `UBF_T_VENDOR) |-> r.len <= 16'(VS_MAX))
		else $error("vendor block too long");
	chk_header_len: assert property ((r.st == ST_TYPE &&
		r.kind == `UBF_T_HEADER) |-> r.len >= 16'h0007 && !$past(r.nb))
		else $error("header length below seven");
	chk_header_first: assert property ((r.st == ST_PAY &&
		r.kind == `UBF_T_HEADER && r.idx == 8'h00) |=>
		o_data[7:6] == 2'b00 ##1 o_data[7:6] == 2'b00)
		else $error("header reserved bits set");
	chk_trailer_len: assert property ((r.st == ST_TYPE &&
		r.kind == `UBF_T_TRAILER) |-> r.len >= 16'h0004)
		else $error("trailer length below four");
	chk_count_hold: assert property ((r.counting &&
		r.clean == 8'hFF && r.st != ST_IDLE) |=> r.clean == 8'hFF)
		else $error("code block count wrapped");
	chk_fec_off: assert property ((r.st == ST_PAY &&
		r.kind == `UBF_T_TRAILER && !r.fec_en &&
		r.idx > r.k) |=> o_data == 8'h00)
		else $error("count nonzero with coding off");
	chk_middle_order: assert property ((r.st == ST_TYPE &&
		r.kind == `UBF_T_MIDDLE) |-> !r.first && r.len == 16'(CHUNK))
		else $error("middle block misplaced or short");
	chk_no_burst: assert property ((r.st == ST_IDLE && i_no_burst &&
		!i_burst_start) |=> r.kind == `UBF_T_NOBURST && r.nb)
		else $error("no-burst block not started");
endmodule // upstream_burst_block_framer
`default_nettype wire

/* File: pkg/ubf_defs.svh */
/*
 * Constants of the upstream burst block framer: block type codes, field
 * sizes, register offsets and reset values. Assumes byte-wide framing.
 */
`ifndef UBF_DEFS_SVH
`define UBF_DEFS_SVH

// -----------------------------------------------------------------
// block type codes
// -----------------------------------------------------------------
`define UBF_T_HEADER 8'h01
`define UBF_T_MIDDLE 8'h02
`define UBF_T_TRAILER 8'h03
`define UBF_T_VENDOR 8'h04
`define UBF_T_NOBURST 8'h05
`define UBF_T_TAG 8'h06

// -----------------------------------------------------------------
// payload sizes
// -----------------------------------------------------------------
`define UBF_CHUNK 16
`define UBF_VS_MAX 128
`define UBF_HDR_FIX 8'h07
`define UBF_TRL_FIX 8'h04
`define UBF_NB_FIX 8'h09

// -----------------------------------------------------------------
// registers
// -----------------------------------------------------------------
`define UBF_A_CTRL 8'h00
`define UBF_A_INT_STAT 8'h04
`define UBF_A_INT_MASK 8'h08
`define UBF_A_VS_DATA 8'h0C
`define UBF_A_VS_LEN 8'h10
`define UBF_A_STATUS 8'h14
`define UBF_RST_CTRL 1'h0
`define UBF_RST_MASK 4'h0
`define UBF_I_BURST 0
`define UBF_I_NOBURST 1
`define UBF_I_VS_OVF 2
`define UBF_I_DROP 3

`endif

/* File: pkg/ubf_pkg.sv */
/*
 * Types of the upstream burst block framer.
 * Assumes ubf_defs.svh for all numeric constants but the state codes.
 */
`default_nettype none
package ubf_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_TAG = 7'b0000010,
		ST_COLLECT = 7'b0000100,
		ST_TYPE = 7'b0001000,
		ST_LEN_HI = 7'b0010000,
		ST_LEN_LO = 7'b0100000,
		ST_PAY = 7'b1000000
	} fr_state_t;
endpackage
`default_nettype wire

/* File: dv/mac_block_sink.sv */
/*
 * MAC-side block sink: collects every framer byte and walks the block
 * headers to find where each payload ends.
 * Assumes one byte per clock while valid and no back-pressure.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ubf_defs.svh"

module mac_block_sink (
	input wire logic i_clk, // framer clock
	input wire logic i_rst_b, // async, active low
	input wire logic [7:0] i_data, // block byte
	input wire logic i_valid // byte valid
);
	logic [7:0] got[$];
	logic [7:0] typ;
	int left; // payload bytes still owed to the current block
	int hdr; // length bytes still to come
	int bad; // malformed blocks seen

	// -----------------------------------------------------------------
	// parser
	// -----------------------------------------------------------------
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			left = 0;
			hdr = 0;
			bad = 0;
		end else if (i_valid) begin
			got.push_back(i_data);
			if (hdr == 2) begin
				left = 256 * i_data;
				hdr = 1;
			end else if (hdr == 1) begin
				left += i_data;
				hdr = 0;
				if (typ == `UBF_T_VENDOR && left > `UBF_VS_MAX)
					bad++;
			end else if (left > 0) begin
				left--;
			end else begin
				typ = i_data;
				// payload meaning is chosen by the type byte alone
				if (typ == `UBF_T_TAG)
					left = 1;
				else if (typ >= `UBF_T_HEADER && typ < `UBF_T_TAG)
					hdr = 2;
				else
					bad++;
			end
		end
	end
endmodule // mac_block_sink
`default_nettype wire

/* File: dv/upstream_burst_block_framer_tb.sv */
/*
 * Testbench of the upstream burst block framer: bursts, no-burst,
 * vendor block, registers and interrupt, checked byte by byte.
 * Assumes mac_block_sink as the MAC and the design's default sizes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ubf_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin \
	fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); \
	end end

module upstream_burst_block_framer_tb;
	logic i_clk, i_rst_b, i_burst_start, i_no_burst, i_new_descriptor;
	logic i_fec_enable, i_collision, i_no_energy, i_in_valid, i_in_last;
	logic i_rx_internal_error, i_low_energy, i_high_energy, i_wr, i_rd;
	logic i_clean_code_block, i_fixed_code_block, i_failed_code_block;
	logic [3:0] i_interval_usage_code;
	logic [13:0] i_service_flow_id;
	logic [31:0] i_burst_start_slot_index, i_wr_data, o_rd_data;
	logic [2:0] i_channel;
	logic [15:0] i_opportunity_length;
	logic [7:0] i_in_data, i_addr, o_data;
	logic o_valid, o_in_ready, o_busy, o_irq, tag_on;
	logic [7:0] exp[$], vq[$];
	int fail_count, checks, cyc;

	upstream_burst_block_framer dut (.i_clk, .i_rst_b, .i_burst_start,
		.i_no_burst, .i_interval_usage_code, .i_service_flow_id,
		.i_burst_start_slot_index, .i_new_descriptor, .i_fec_enable,
		.i_channel, .i_collision, .i_no_energy, .i_opportunity_length,
		.i_in_data, .i_in_valid, .i_in_last, .i_rx_internal_error,
		.i_low_energy, .i_high_energy, .i_clean_code_block,
		.i_fixed_code_block, .i_failed_code_block, .i_addr, .i_wr_data,
		.i_wr, .i_rd, .o_rd_data, .o_data, .o_valid, .o_in_ready, .o_busy,
		.o_irq);
	mac_block_sink sink (.i_clk, .i_rst_b, .i_data(o_data),
		.i_valid(o_valid));

	// -----------------------------------------------------------------
	// clock, timeout, closing
	// -----------------------------------------------------------------
	always #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// bus and stream helpers
	// -----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		`CHK(o_rd_data, e)
	endtask

	task automatic put16(input logic [15:0] v);
		exp.push_back(v[15:8]);
		exp.push_back(v[7:0]);
	endtask

	task automatic put_data(input int from, input int cnt);
		for (int k = from; k < from + cnt; k++)
			exp.push_back(8'(k + 8'h30));
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		repeat (3) @(negedge i_clk);
		`CHK(o_busy, 1'b1)
		while ((o_busy || o_valid) && k < 600) begin
			@(negedge i_clk);
			k++;
		end
		// margin so the caller looks at settled levels
		repeat (3) @(negedge i_clk);
	endtask

	task automatic cmp_stream();
		`CHK(sink.got.size(), exp.size())
		for (int i = 0; i < exp.size() && i < sink.got.size(); i++)
			`CHK(sink.got[i], exp[i])
		`CHK(sink.bad, 0)
		`CHK(o_busy, 1'b0)
		`CHK(o_in_ready, 1'b0)
	endtask

	// burst of n bytes, p cycles of code block pulses before the data
	task automatic burst(input int n, input int p, input logic fec,
		input logic [2:0] fl, input logic again);
		int h;
		int rem;
		sink.got.delete();
		@(posedge i_clk);
		i_burst_start <= 1'b1;
		i_fec_enable <= fec;
		i_new_descriptor <= n[0];
		i_interval_usage_code <= 4'hA;
		i_service_flow_id <= 14'h2A5C;
		i_burst_start_slot_index <= 32'h89AB_CDEF;
		i_channel <= 3'h2;
		{i_rx_internal_error, i_low_energy, i_high_energy} <= fl;
		@(posedge i_clk);
		for (int k = 0; k < p; k++) begin
			i_burst_start <= (again && k == 2);
			i_clean_code_block <= 1'b1;
			i_fixed_code_block <= (k < 3);
			i_failed_code_block <= (k == 0);
			@(posedge i_clk);
		end
		i_clean_code_block <= 1'b0;
		i_fixed_code_block <= 1'b0;
		for (int k = 0; k < n; k++) begin
			i_in_data <= 8'(k + 8'h30);
			i_in_valid <= 1'b1;
			i_in_last <= (k == n - 1);
			@(negedge i_clk);
			while (!o_in_ready)
				@(negedge i_clk);
			@(posedge i_clk);
		end
		i_in_valid <= 1'b0;
		i_in_last <= 1'b0;
		h = (n < 16) ? n : 16;
		exp = {`UBF_T_HEADER};
		if (tag_on)
			exp = {`UBF_T_TAG, 8'h02, exp};
		put16(16'(h + 7));
		exp.push_back({2'b00, n[0], vq.size() > 0, 4'hA});
		put16(16'h2A5C);
		put16(16'h89AB);
		put16(16'hCDEF);
		put_data(0, h);
		rem = n - h;
		while (rem > 16) begin
			exp.push_back(`UBF_T_MIDDLE);
			put16(16'h0010);
			put_data(n - rem, 16);
			rem -= 16;
		end
		exp.push_back(`UBF_T_TRAILER);
		put16(16'(rem + 4));
		put_data(n - rem, rem);
		exp.push_back({5'b00000, fl});
		exp.push_back(fec ? ((p > 255) ? 8'hFF : 8'(p)) : 8'h00);
		exp.push_back(fec ? 8'h03 : 8'h00);
		exp.push_back(fec ? 8'h01 : 8'h00);
		if (vq.size() > 0) begin
			exp.push_back(`UBF_T_VENDOR);
			put16(16'(vq.size()));
			exp = {exp, vq};
		end
		wait_idle();
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_regs();
		rdc(`UBF_A_CTRL, 32'h0);
		rdc(`UBF_A_INT_MASK, 32'h0);
		rdc(8'h40, 32'h0);
		`CHK(o_irq, 1'b0)
		wr(`UBF_A_INT_MASK, 32'h1);
		$display("test registers done");
	endtask

	task automatic t_short();
		burst(1, 300, 1'b1, 3'b101, 1'b0);
		cmp_stream();
		`CHK(o_irq, 1'b1)
		rdc(`UBF_A_INT_STAT, 32'h1);
		@(negedge i_clk);
		`CHK(o_irq, 1'b0)
		$display("test short burst done");
	endtask

	task automatic t_long();
		wr(`UBF_A_CTRL, 32'h1);
		tag_on = 1'b1;
		burst(33, 4, 1'b0, 3'b010, 1'b1);
		cmp_stream();
		tag_on = 1'b0;
		wr(`UBF_A_CTRL, 32'h0);
		rdc(`UBF_A_INT_STAT, 32'h9);
		$display("test long burst done");
	endtask

	task automatic t_vendor();
		for (int b = 0; b < 129; b++)
			wr(`UBF_A_VS_DATA, 32'(b));
		rdc(`UBF_A_INT_STAT, 32'h4);
		rdc(`UBF_A_VS_LEN, 32'h80);
		wr(`UBF_A_VS_LEN, 32'h0);
		for (int b = 0; b < 3; b++) begin
			wr(`UBF_A_VS_DATA, 32'(8'hC0 + b));
			vq.push_back(8'(8'hC0 + b));
		end
		burst(16, 4, 1'b1, 3'b000, 1'b0);
		cmp_stream();
		vq.delete();
		rdc(`UBF_A_INT_STAT, 32'h1);
		rdc(`UBF_A_VS_LEN, 32'h0);
		$display("test vendor block done");
	endtask

	task automatic t_noburst();
		wr(`UBF_A_CTRL, 32'h1);
		rdc(`UBF_A_CTRL, 32'h1);
		sink.got.delete();
		@(posedge i_clk);
		i_no_burst <= 1'b1;
		i_channel <= 3'h5;
		i_collision <= 1'b1;
		i_interval_usage_code <= 4'h3;
		i_service_flow_id <= 14'h1F0E;
		i_opportunity_length <= 16'h0123;
		@(posedge i_clk);
		i_no_burst <= 1'b0;
		exp = {`UBF_T_TAG, 8'h05, `UBF_T_NOBURST, 8'h00, `UBF_NB_FIX,
			8'h9F, 8'h0E, 8'h89, 8'hAB, 8'hCD, 8'hEF, 8'h03, 8'h01, 8'h23};
		wait_idle();
		cmp_stream();
		`CHK(o_irq, 1'b0)
		rdc(`UBF_A_INT_STAT, 32'h2);
		rdc(`UBF_A_STATUS, 32'h55);
		wr(`UBF_A_CTRL, 32'h0);
		$display("test no burst done");
	endtask

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		i_rst_b = 1'b0;
		{i_burst_start, i_no_burst, i_new_descriptor, i_fec_enable,
			i_collision, i_no_energy, i_in_valid, i_in_last,
			i_rx_internal_error, i_low_energy, i_high_energy, i_wr, i_rd,
			i_clean_code_block, i_fixed_code_block,
			i_failed_code_block} = '0;
		{i_interval_usage_code, i_service_flow_id, i_channel} = '0;
		{i_burst_start_slot_index, i_wr_data, i_opportunity_length} = '0;
		{i_in_data, i_addr} = '0;
		tag_on = 1'b0;
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_regs();
		t_short();
		t_long();
		t_vendor();
		t_noburst();
		report_and_stop();
	end
endmodule // upstream_burst_block_framer_tb
`default_nettype wire
